// ==== src_far_model.sv ====
// modulator and host port stand-in
`timescale 1ns/1ps
`default_nettype none
module src_far_model(input wire logic refClk,modStrobe,dacTake,rnd,
  input wire logic [15:0] word,output logic adcBit=0,output logic [15:0] dacSample=0);
  integer seed=8009;
  always @(posedge refClk)begin
    if(modStrobe)adcBit<=rnd&1'($random(seed));
    if(dacTake)dacSample<=rnd?16'($random(seed)):word;
  end
endmodule
`default_nettype wire

// ==== src_pkg.sv ====
// package: constants and carriers for the sinc3 rate converter
package src_pkg;
  localparam logic [1:0] RATE_64K = 2'h0;
  localparam logic [1:0] RATE_32K = 2'h1;
  localparam logic [1:0] RATE_16K = 2'h2;
  localparam logic [1:0] RATE_8K = 2'h3;
  localparam int MOD_DIV = 8;
  localparam int LOG2_RATIO_MIN = 5;
  localparam int LOG2_RATIO_MAX = 8;
  localparam int ACC_W = 1 + 3 * LOG2_RATIO_MAX;
  localparam int IACC_W = 16 + 3 * LOG2_RATIO_MAX;
  localparam logic [2:0] MDIV_RESET = 3'h0;
  localparam int SMP_CNT_W = LOG2_RATIO_MAX;
  localparam int MDIV_CNT_W = 3;
  localparam int MOD_CNT_W = 3;

  typedef struct packed {
    logic [MDIV_CNT_W-1:0] mdivCnt;
    logic [MOD_CNT_W-1:0] modCnt;
    logic [SMP_CNT_W-1:0] smpCnt;
    logic [ACC_W-1:0] dInt1;
    logic [ACC_W-1:0] dInt2;
    logic [ACC_W-1:0] dInt3;
    logic [ACC_W-1:0] dComb1;
    logic [ACC_W-1:0] dComb2;
    logic [ACC_W-1:0] dComb3;
    logic [15:0] adcWord;
    logic adcValid;
    logic [IACC_W-1:0] iDiff1;
    logic [IACC_W-1:0] iDiff2;
    logic [IACC_W-1:0] iDiff3;
    logic [IACC_W-1:0] iComb3;
    logic [IACC_W-1:0] iAcc1;
    logic [IACC_W-1:0] iAcc2;
    logic [IACC_W-1:0] iAcc3;
    logic [15:0] dacHold;
    logic [15:0] dacWord;
  } src_state_t;
endpackage

// ==== src_props.sv ====
// port timing checks
`timescale 1ns/1ps
`default_nettype none
module src_props(input wire logic refClk,nrst,modStrobe,adcStrobe,dacTake,
  input wire logic [2:0] mdivSel,input wire logic [1:0] rateSel,
  input wire logic [15:0] adcSample,dacWord);
  default clocking @(posedge refClk);endclocking
  default disable iff(!nrst);
  property p_m;modStrobe&&mdivSel==3'h0|=>!modStrobe[*7]##1 modStrobe;endproperty
  a_m:assert property(p_m)else $error("m");
  property p_v;modStrobe&&mdivSel==3'h1|->##16 modStrobe;endproperty
  a_v:assert property(p_v)else $error("v");
  property p_g;dacTake&&rateSel==2'h0&&mdivSel==3'h0|->##256 dacTake;endproperty
  a_g:assert property(p_g)else $error("g");
  property p_t;dacTake|->modStrobe;endproperty
  a_t:assert property(p_t)else $error("t");
  property p_a;dacTake|=>adcStrobe;endproperty
  a_a:assert property(p_a)else $error("a");
  property p_o;adcStrobe|->$past(dacTake);endproperty
  a_o:assert property(p_o)else $error("o");
  property p_h;!adcStrobe|->$stable(adcSample);endproperty
  a_h:assert property(p_h)else $error("h");
  property p_d;!$past(modStrobe)|->$stable(dacWord);endproperty
  a_d:assert property(p_d)else $error("d");
endmodule
bind src_sinc3_rate_converter src_props i_p(.*);
`default_nettype wire

// ==== src_sinc3_rate_converter.sv ====
// sinc3 decimator and interpolator sharing one divided modulator clock
`timescale 1ns/1ps
`default_nettype none
module src_sinc3_rate_converter (
  input wire logic refClk, // 50 MHz ref_clk
  input wire logic nrst, // async reset, active low
  input wire logic [2:0] mdivSel, // master divide ratio minus one
  input wire logic [1:0] rateSel, // sample rate select
  input wire logic intBypass, // skip interpolation filter
  input wire logic adcBit, // adc modulator bitstream
  output logic modStrobe, // modulator sample enable pulse
  output logic [15:0] adcSample, // output sample register
  output logic adcStrobe, // pulse: new adc word
  input wire logic [15:0] dacSample, // input sample register
  output logic dacTake, // pulse: dacSample consumed
  output logic [15:0] dacWord // word to dac modulator
);
  src_pkg::src_state_t st_reg, st_next;
  logic dmclkEn, modEn, smpEn;
  logic [3:0] log2Ratio;
  logic [src_pkg::SMP_CNT_W-1:0] smpMax;
  logic [src_pkg::ACC_W-1:0] inBit, c1, c2, c3;
  logic [src_pkg::IACC_W-1:0] xIn, d1, d2, d3;
  logic [16:0] adcScaled;

  always_comb begin
    log2Ratio = 4'(src_pkg::LOG2_RATIO_MIN) + {2'h0, rateSel};
    smpMax = src_pkg::SMP_CNT_W'((9'h1 << log2Ratio) - 9'h1);
    dmclkEn = (st_reg.mdivCnt == mdivSel);
    modEn = dmclkEn && (st_reg.modCnt == 3'(src_pkg::MOD_DIV - 1));
    smpEn = modEn && (st_reg.smpCnt == smpMax);
    inBit = adcBit ? src_pkg::ACC_W'(1) : '0;
    c1 = st_reg.dInt3 - st_reg.dComb1;
    c2 = c1 - st_reg.dComb2;
    c3 = c2 - st_reg.dComb3;
    // gain is ratio cubed; shift down so full scale lands on bit 15
    adcScaled = 17'(c3 >> (3 * log2Ratio - 15));
    xIn = src_pkg::IACC_W'(signed'(st_reg.dacHold));
    d1 = xIn - st_reg.iDiff1;
    d2 = d1 - st_reg.iDiff2;
    d3 = d2 - st_reg.iComb3;
    st_next = st_reg;
    st_next.adcValid = 1'b0;
    st_next.mdivCnt = dmclkEn ? '0 : st_reg.mdivCnt + 3'h1;
    if (dmclkEn) begin
      st_next.modCnt = st_reg.modCnt + 3'h1;
    end
    if (modEn) begin
      st_next.smpCnt = smpEn ? '0 : st_reg.smpCnt + 1'b1;
      // modular wraparound keeps the cic exact without saturation
      st_next.dInt1 = st_reg.dInt1 + inBit;
      st_next.dInt2 = st_reg.dInt2 + st_reg.dInt1;
      st_next.dInt3 = st_reg.dInt3 + st_reg.dInt2;
      st_next.iAcc1 = st_reg.iAcc1 + st_reg.iDiff3;
      st_next.iAcc2 = st_reg.iAcc2 + st_reg.iAcc1;
      st_next.iAcc3 = st_reg.iAcc3 + st_reg.iAcc2;
      if (intBypass) begin
        st_next.dacWord = st_reg.dacHold;
      end else begin
        // zero stuffing leaves a gain of ratio squared; scale back to 16 bits
        st_next.dacWord = 16'(st_reg.iAcc3 >> (2 * log2Ratio));
      end
      st_next.iDiff3 = '0;
    end
    if (smpEn) begin
      st_next.dComb1 = st_reg.dInt3;
      st_next.dComb2 = c1;
      st_next.dComb3 = c2;
      // unipolar count 0..R^3 mapped to signed 16 bits; all ones (R^3) lands on bit 15 and wraps to 16'h0000
      st_next.adcWord = (adcScaled[16] ? 16'hffff : adcScaled[15:0]) ^ 16'h8000;
      st_next.adcValid = 1'b1;
      st_next.dacHold = dacSample;
      st_next.iDiff1 = xIn;
      st_next.iDiff2 = d1;
      st_next.iComb3 = d2;
      st_next.iDiff3 = d3;
    end
  end

  always_ff @(posedge refClk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign modStrobe = modEn;
  assign adcSample = st_reg.adcWord;
  assign adcStrobe = st_reg.adcValid;
  assign dacTake = smpEn;
  assign dacWord = st_reg.dacWord;
endmodule
`default_nettype wire

// ==== src_sinc3_rate_converter_tb.sv ====
// bench of the rate converter
`timescale 1ns/1ps
`default_nettype none
module src_sinc3_rate_converter_tb;
  logic refClk=0,nrst=0,intBypass=0,rnd=1,adcBit,modStrobe,adcStrobe,dacTake;
  logic [2:0] mdivSel=0;
  logic [1:0] rateSel=0;
  logic [15:0] word=0,adcSample,dacSample,dacWord,q[$];
  int mismatches=0,checked=0,n;
  always #10 refClk=~refClk;
  src_sinc3_rate_converter i_dut(.*);
  src_far_model i_far(.*);
  task chk(string s,logic [15:0] e,g);
    checked++;
    if(g!==e)begin mismatches++;$display("BAD %s exp %h got %h",s,e,g);end
  endtask
  task test_done;
    $display("checked %0d mismatches %0d",checked,mismatches);
    if(mismatches==0&&checked>0)$display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(negedge refClk)if(adcStrobe&&q.size()>0)chk("adc",q.pop_front(),adcSample);
  initial begin #1200000;mismatches++;test_done;end
  initial begin
    for(int i=0;i<6;i++)begin
      @(posedge refClk);
      {nrst,rnd,intBypass}<={1'h0,1'h1,i==5};
      {rateSel,mdivSel}<={2'(i),3'(i==4)};
      word<=16'h5a3c^16'(i);
      n=(8<<(i==4))*(32<<(i%4));
      repeat(20)@(posedge refClk);
      nrst<=1'h1;
      // random bits first so the zero run must flush real history
      repeat(2*n)@(posedge refClk);
      rnd<=1'h0;
      repeat(5*n)@(posedge refClk);
      q.push_back(16'h8000);
      repeat(n+9)@(posedge refClk);
      @(negedge refClk);
      chk("pend",16'h0,16'(q.size()));
      if(intBypass)chk("dac",word,dacWord);
      else chk("dacint",word,dacWord);
    end
    test_done;
  end
endmodule
`default_nettype wire
